// File: common/itsc_regs.vh
// constants of the serial-bus target with clock stretching and crc
// assumes the includer runs on a 250 MHz core clock
`ifndef ITSC_REGS_VH
`define ITSC_REGS_VH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define ITSC_CLK_KHZ        250000
`define ITSC_STRETCH_MAX_MS 5
`define ITSC_STRETCH_CYC    (`ITSC_STRETCH_MAX_MS * `ITSC_CLK_KHZ)

// ----------------------------------------------------------------
// crc
// ----------------------------------------------------------------
`define ITSC_CRC_INIT       8'hff
`define ITSC_CRC_POLY       8'h07

// ----------------------------------------------------------------
// control word, first byte (control word bits 23..16)
// ----------------------------------------------------------------
`define ITSC_CW_DIR_BIT     7
`define ITSC_CW_CRC_BIT     6
`define ITSC_CW_LEN_HI      5
`define ITSC_CW_LEN_LO      4
`define ITSC_CW_BYTES       4'h3

// ----------------------------------------------------------------
// transmit buffer
// ----------------------------------------------------------------
`define ITSC_TXF_WIDTH      8
`define ITSC_TXF_DEPTH      32
`define ITSC_TXF_AW         5

`endif

// File: logic/itsc_fifo.v
// fifo with valid/ready on both sides and registered read data
// assumes a single clock and a synchronous active-low reset
`timescale 1ns/1ps

module itsc_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 32,
	parameter AW    = 5
) (
	// clock and reset
	input  wire             clk,
	input  wire             rst_n,
	input  wire             flush,
	// fill side
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	// drain side
	output wire             out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data
);

	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW:0]      wptr_r;
	reg [AW:0]      rptr_r;
	reg [WIDTH-1:0] dout_r;
	reg             dval_r;
	wire            mem_empty;
	wire            push;
	wire            load;

	assign mem_empty = (wptr_r == rptr_r);
	assign in_ready  = (wptr_r - rptr_r) != DEPTH[AW:0];
	assign push      = in_valid & in_ready;
	// output stage refills when empty or taken this cycle
	assign load      = ~mem_empty & (~dval_r | out_ready);
	assign out_valid = dval_r;
	assign out_data  = dout_r;

	always @(posedge clk) begin
		if (push)
			mem[wptr_r[AW-1:0]] <= in_data;
	end

	always @(posedge clk) begin
		if (!rst_n || flush) begin
			wptr_r <= {(AW+1){1'b0}};
			rptr_r <= {(AW+1){1'b0}};
			dval_r <= 1'b0;
			dout_r <= {WIDTH{1'b0}};
		end else begin
			if (push)
				wptr_r <= wptr_r + 1'b1;
			if (load) begin
				dout_r <= mem[rptr_r[AW-1:0]];
				rptr_r <= rptr_r + 1'b1;
				dval_r <= 1'b1;
			end else if (out_ready)
				dval_r <= 1'b0;
		end
	end

endmodule // itsc_fifo

// File: logic/itsc_target.v
// serial-bus target: address match, clock stretching, crc check and append
// assumes the bus pins are open drain, resolved outside; user logic on ref_clk
//
// Behaviour
// - hold clock low while any stretch condition
// - address match raises start event, stretch, ack
// - new start waits behind unserviced receive event
// - second byte stretches until first serviced
// - read stretches until transmit buffer holds data
// - stretch ends after 5 ms
// - crc8 poly 0x07, initial value 0xff
// - write crc mismatch raises wr_crc_bad instead of wr_done; bytes already handed on
// - read sends crc byte after last data
// - read crc covers both addresses, control, data
// - control bit 22 enables crc byte
// - bits 21-20 set length, msb first
`timescale 1ns/1ps
`include "itsc_regs.vh"

module itsc_target #(
	parameter STRETCH_CYC = `ITSC_STRETCH_CYC
) (
	// clock and reset
	input  wire       ref_clk,
	input  wire       arst_n,
	// own address
	input  wire [6:0] own_addr,
	// bus pins, open drain
	input  wire       scl_in,
	output wire       scl_out,
	output wire       scl_oe,
	input  wire       sda_in,
	output wire       sda_out,
	output wire       sda_oe,
	// start event
	output wire       start_evt,
	input  wire       start_ack,
	// receive event
	output wire       rx_evt,
	output wire [7:0] rx_data,
	output wire       rx_ctrl,
	input  wire       rx_ack,
	// write outcome and abort of any transfer
	output wire       wr_done,
	output wire       wr_crc_bad,
	output wire       xfer_abort,
	// transmit buffer fill
	input  wire       tx_valid,
	output wire       tx_ready,
	input  wire [7:0] tx_data
);

	localparam S_IDLE  = 4'h0;
	localparam S_ADDR  = 4'h1;
	localparam S_AHOLD = 4'h2;
	localparam S_ACK   = 4'h3;
	localparam S_RX    = 4'h4;
	localparam S_RHOLD = 4'h5;
	localparam S_THOLD = 4'h6;
	localparam S_TX    = 4'h7;
	localparam S_MACK  = 4'h8;

	// ----------------------------------------------------------------
	// crc step
	// ----------------------------------------------------------------
	function [7:0] crc8;
		input [7:0] c;
		input [7:0] d;
		integer     i;
		reg   [7:0] r;
		begin
			r = c ^ d;
			for (i = 0; i < 8; i = i + 1)
				r = r[7] ? ((r << 1) ^ `ITSC_CRC_POLY) : (r << 1);
			crc8 = r;
		end
	endfunction

	// ----------------------------------------------------------------
	// reset release and pin synchronisers
	// ----------------------------------------------------------------
	reg  [1:0] rst_sync_r;
	wire       rst_n;
	reg        scl_m_r, scl_s_r, scl_q_r;
	reg        sda_m_r, sda_s_r, sda_q_r;

	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n)
			rst_sync_r <= 2'b00;
		else
			rst_sync_r <= {rst_sync_r[0], 1'b1};
	end
	assign rst_n = rst_sync_r[1];

	always @(posedge ref_clk) begin
		if (!rst_n) begin
			{scl_m_r, scl_s_r, scl_q_r} <= 3'b111;
			{sda_m_r, sda_s_r, sda_q_r} <= 3'b111;
		end else begin
			{scl_m_r, scl_s_r, scl_q_r} <= {scl_in, scl_m_r, scl_s_r};
			{sda_m_r, sda_s_r, sda_q_r} <= {sda_in, sda_m_r, sda_s_r};
		end
	end

	wire scl_rise = scl_s_r & ~scl_q_r;
	wire scl_fall = ~scl_s_r & scl_q_r;
	wire bus_start = scl_s_r & scl_q_r & sda_q_r & ~sda_s_r;
	wire bus_stop  = scl_s_r & scl_q_r & ~sda_q_r & sda_s_r;

	// ----------------------------------------------------------------
	// transmit buffer
	// ----------------------------------------------------------------
	wire       txf_valid;
	wire [7:0] txf_data;
	reg        txf_pop;
	reg        txf_flush;

	itsc_fifo #(
		.WIDTH (`ITSC_TXF_WIDTH),
		.DEPTH (`ITSC_TXF_DEPTH),
		.AW    (`ITSC_TXF_AW)
	) i_itsc_fifo (
		.clk       (ref_clk),
		.rst_n     (rst_n),
		.flush     (txf_flush),
		.in_valid  (tx_valid),
		.in_ready  (tx_ready),
		.in_data   (tx_data),
		.out_valid (txf_valid),
		.out_ready (txf_pop),
		.out_data  (txf_data)
	);

	// ----------------------------------------------------------------
	// protocol engine
	// ----------------------------------------------------------------
	reg [3:0]  state_r, ack_next_r;
	reg [7:0]  sh_r, tx_sh_r, crc_r, rx_data_r;
	reg [3:0]  bit_r, byte_r, len_r;
	reg        rd_r, crc_en_r, wr_op_r, nack_r, sda_drv_r;
	reg        st_pend_r, st_wait_r, rx_pend_r, rx_ctrl_r;
	reg        wr_done_r, crc_bad_r, abort_r;
	reg [31:0] tmo_r;

	wire stretching = (state_r == S_AHOLD) | (state_r == S_RHOLD) |
		(state_r == S_THOLD);
	wire timeout = stretching & (tmo_r >= STRETCH_CYC - 1);
	// payload bytes after the control word; crc byte follows when enabled
	wire [3:0] data_end = `ITSC_CW_BYTES + len_r;
	wire       rx_is_crc = crc_en_r & (byte_r == data_end);

	assign scl_out    = 1'b0;
	assign sda_out    = 1'b0;
	assign scl_oe     = stretching;
	assign sda_oe     = sda_drv_r;
	assign start_evt  = st_pend_r;
	assign rx_evt     = rx_pend_r;
	assign rx_data    = rx_data_r;
	assign rx_ctrl    = rx_ctrl_r;
	assign wr_done    = wr_done_r;
	assign wr_crc_bad = crc_bad_r;
	assign xfer_abort = abort_r;

	always @* begin
		txf_pop   = (state_r == S_THOLD) & txf_valid & (byte_r < len_r);
		txf_flush = (state_r == S_AHOLD) & ~rd_r & (tmo_r == 32'h0);
	end

	always @(posedge ref_clk) begin
		if (!rst_n || !stretching)
			tmo_r <= 32'h0;
		else
			tmo_r <= tmo_r + 32'h1;
	end

	always @(posedge ref_clk) begin
		if (!rst_n) begin
			state_r    <= S_IDLE;
			ack_next_r <= S_IDLE;
			sh_r       <= 8'h00;
			tx_sh_r    <= 8'h00;
			crc_r      <= `ITSC_CRC_INIT;
			rx_data_r  <= 8'h00;
			bit_r      <= 4'h0;
			byte_r     <= 4'h0;
			len_r      <= 4'h2;
			rd_r       <= 1'b0;
			crc_en_r   <= 1'b0;
			wr_op_r    <= 1'b0;
			nack_r     <= 1'b0;
			sda_drv_r  <= 1'b0;
			st_pend_r  <= 1'b0;
			st_wait_r  <= 1'b0;
			rx_pend_r  <= 1'b0;
			rx_ctrl_r  <= 1'b0;
			wr_done_r  <= 1'b0;
			crc_bad_r  <= 1'b0;
			abort_r    <= 1'b0;
		end else begin
			wr_done_r <= 1'b0;
			crc_bad_r <= 1'b0;
			abort_r   <= 1'b0;
			// service clears, a new set in the same cycle wins
			if (start_ack)
				st_pend_r <= 1'b0;
			if (rx_ack)
				rx_pend_r <= 1'b0;
			// start event queued behind an older receive event
			// an older start still pending keeps the new one queued
			if (st_wait_r && !rx_pend_r && !st_pend_r) begin
				st_pend_r <= 1'b1;
				st_wait_r <= 1'b0;
			end
			if (timeout) begin
				state_r   <= S_IDLE;
				sda_drv_r <= 1'b0;
				st_wait_r <= 1'b0;
				abort_r   <= 1'b1;
			end else if (bus_start) begin
				state_r   <= S_ADDR;
				bit_r     <= 4'h0;
				sda_drv_r <= 1'b0;
			end else if (bus_stop) begin
				state_r   <= S_IDLE;
				sda_drv_r <= 1'b0;
			end else begin
				case (state_r)
				S_ADDR, S_RX: begin
					if (scl_rise) begin
						sh_r  <= {sh_r[6:0], sda_s_r};
						bit_r <= bit_r + 4'h1;
					end else if (scl_fall && bit_r == 4'h8) begin
						if (state_r == S_RX)
							state_r <= S_RHOLD;
						else if (sh_r[7:1] == own_addr) begin
							state_r   <= S_AHOLD;
							rd_r      <= sh_r[0];
							st_wait_r <= 1'b1;
							// write address restarts crc, read address continues it
							crc_r <= sh_r[0] ? crc8(crc_r, sh_r) :
								crc8(`ITSC_CRC_INIT, sh_r);
						end else
							state_r <= S_IDLE;
					end
				end
				S_AHOLD: begin
					if (!st_wait_r && !st_pend_r) begin
						state_r    <= S_ACK;
						sda_drv_r  <= 1'b1;
						byte_r     <= 4'h0;
						ack_next_r <= rd_r ? S_THOLD : S_RX;
					end
				end
				S_ACK: begin
					if (scl_fall) begin
						sda_drv_r <= 1'b0;
						bit_r     <= 4'h0;
						state_r   <= ack_next_r;
					end
				end
				S_RHOLD: begin
					if (!wr_op_r && byte_r >= `ITSC_CW_BYTES && rx_is_crc) begin
						// crc byte is checked, never handed on
						wr_done_r <= (sh_r == crc_r);
						crc_bad_r <= (sh_r != crc_r);
						byte_r    <= byte_r + 4'h1;
						state_r   <= S_ACK;
						sda_drv_r <= 1'b1;
						ack_next_r <= S_RX;
					end else if (!rx_pend_r) begin
						rx_data_r <= sh_r;
						rx_ctrl_r <= (byte_r < `ITSC_CW_BYTES);
						rx_pend_r <= 1'b1;
						crc_r     <= crc8(crc_r, sh_r);
						if (byte_r == 4'h0) begin
							wr_op_r  <= sh_r[`ITSC_CW_DIR_BIT];
							crc_en_r <= sh_r[`ITSC_CW_CRC_BIT];
							case (sh_r[`ITSC_CW_LEN_HI:`ITSC_CW_LEN_LO])
							2'b00:   len_r <= 4'h2;
							2'b01:   len_r <= 4'h4;
							default: len_r <= 4'h8;
							endcase
						end
						if (byte_r >= `ITSC_CW_BYTES && !crc_en_r && !wr_op_r &&
							byte_r == data_end - 4'h1)
							wr_done_r <= 1'b1;
						if (byte_r != 4'hf)
							byte_r <= byte_r + 4'h1;
						state_r    <= S_ACK;
						sda_drv_r  <= 1'b1;
						ack_next_r <= S_RX;
					end
				end
				S_THOLD: begin
					bit_r <= 4'h0;
					if (byte_r < len_r) begin
						if (txf_valid) begin
							tx_sh_r   <= txf_data;
							crc_r     <= crc8(crc_r, txf_data);
							sda_drv_r <= ~txf_data[7];
							state_r   <= S_TX;
						end
					end else if (crc_en_r && byte_r == len_r) begin
						tx_sh_r   <= crc_r;
						sda_drv_r <= ~crc_r[7];
						state_r   <= S_TX;
					end else
						state_r <= S_IDLE;
				end
				S_TX: begin
					if (scl_fall) begin
						if (bit_r == 4'h7) begin
							sda_drv_r <= 1'b0;
							state_r   <= S_MACK;
						end else begin
							tx_sh_r   <= {tx_sh_r[6:0], 1'b0};
							sda_drv_r <= ~tx_sh_r[6];
							bit_r     <= bit_r + 4'h1;
						end
					end
				end
				S_MACK: begin
					if (scl_rise)
						nack_r <= sda_s_r;
					else if (scl_fall) begin
						byte_r  <= byte_r + 4'h1;
						state_r <= nack_r ? S_IDLE : S_THOLD;
					end
				end
				default: state_r <= S_IDLE;
				endcase
			end
		end
	end

endmodule // itsc_target

// File: bench/itsc_target_monitor.sv
// checker bound to the serial target, sees its top ports only
// assumes one ref_clk domain and the async active-low reset
`timescale 1ns/1ps
module itsc_target_monitor #(
	parameter STRETCH_CYC = 2000
) (
	// clock and reset
	input wire       ref_clk,
	input wire       arst_n,
	// bus and events
	input wire       scl_oe,
	input wire       sda_oe,
	input wire       start_evt,
	input wire       start_ack,
	input wire       rx_evt,
	input wire [7:0] rx_data,
	input wire       rx_ack,
	input wire       wr_done,
	input wire       wr_crc_bad,
	input wire       xfer_abort
);
	integer hold_r;
	always @(posedge ref_clk or negedge arst_n)
		if (!arst_n)
			hold_r <= 0;
		else
			hold_r <= scl_oe ? hold_r + 1 : 0;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	a_start_holds: assert property ($rose(start_evt) |-> scl_oe)
		else $error("start without hold");
	a_start_release: assert property (start_ack && start_evt && scl_oe
		|-> ##2 !scl_oe && sda_oe) else $error("start not released");
	a_start_clear: assert property (start_ack && start_evt |=> !start_evt)
		else $error("start stays");
	a_start_queued: assert property ($rose(start_evt) |-> !rx_evt)
		else $error("start ahead of byte");
	a_rx_kept: assert property (rx_evt && !rx_ack |=> rx_evt && $stable(rx_data))
		else $error("byte lost");
	a_hold_limit: assert property (hold_r <= STRETCH_CYC + 2)
		else $error("hold too long");
	a_abort_free: assert property (xfer_abort |-> ##[0:1] !scl_oe && !sda_oe)
		else $error("abort kept bus");
	a_crc_verdict: assert property (!(wr_done && wr_crc_bad))
		else $error("two verdicts");
endmodule // itsc_target_monitor
bind itsc_target itsc_target_monitor #(.STRETCH_CYC(STRETCH_CYC)) i_itsc_target_monitor (
	.ref_clk(ref_clk), .arst_n(arst_n), .scl_oe(scl_oe), .sda_oe(sda_oe),
	.start_evt(start_evt), .start_ack(start_ack), .rx_evt(rx_evt), .rx_data(rx_data),
	.rx_ack(rx_ack), .wr_done(wr_done), .wr_crc_bad(wr_crc_bad), .xfer_abort(xfer_abort));

// File: bench/itsc_ctrl_model.sv
// bus controller model: makes the link clock, waits out clock holds
// assumes pulled-up lines resolved by the bench from all enables
`timescale 1ns/1ps
module itsc_ctrl_model (
	// resolved lines
	input  wire  scl,
	input  wire  sda,
	// pull low while 0
	output logic scl_o,
	output logic sda_o
);
	logic hung;
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
		hung  = 1'b0;
	end
	// bounded, so a hold that never ends cannot hang the run
	task rise;
		integer w;
		begin
			scl_o = 1'b1;
			for (w = 0; w < 9000 && scl !== 1'b1; w = w + 1)
				#4;
			if (scl !== 1'b1)
				hung = 1'b1;
		end
	endtask
	task bit_io(input logic bi, output logic bo);
		begin
			sda_o = bi;
			#31.25;
			rise();
			#31.25;
			bo = sda;
			#31.25;
			scl_o = 1'b0;
			#31.25;
		end
	endtask
	task xfer(input logic [7:0] v, input logic ai, output logic [7:0] rv, output logic ack);
		integer i;
		logic   x;
		begin
			for (i = 7; i >= 0; i = i - 1)
				bit_io(v[i], rv[i]);
			bit_io(ai, x);
			ack = !x;
		end
	endtask
	task start;
		begin
			sda_o = 1'b1;
			#31.25;
			rise();
			#62.5;
			sda_o = 1'b0;
			#31.25;
			scl_o = 1'b0;
			#31.25;
		end
	endtask
	task stop;
		begin
			sda_o = 1'b0;
			#31.25;
			rise();
			#31.25;
			sda_o = 1'b1;
			#62.5;
		end
	endtask
endmodule // itsc_ctrl_model

// File: bench/test_itsc_target.sv
// bench: random and corner writes and reads through the controller model
// assumes the checker is bound to the target by its own file
`timescale 1ns/1ps
module test_itsc_target;
	localparam [6:0] ADR = 7'h4b;
	logic        ref_clk, arst_n, start_ack, rx_ack, tx_valid, tx_took, svc, rxh, a;
	logic [7:0]  tx_data, c, r, b0;
	logic [31:0] seed, rs;
	integer      n_fail, checks, n_done, n_bad, n_abt, j, k, n, d0, b1;
	logic [7:0]  q[$], tq[$], e[$];
	wire         scl_oe, sda_oe, scl_o, sda_o, start_evt, rx_evt, wr_done, wr_crc_bad;
	wire         xfer_abort, tx_ready;
	wire [7:0]   rx_data;
	wire         rx_ctrl;
	wire         scl = scl_o & ~scl_oe;
	wire         sda = sda_o & ~sda_oe;
	itsc_target #(.STRETCH_CYC(2000)) i_itsc_target (.ref_clk(ref_clk), .arst_n(arst_n),
		.own_addr(ADR), .scl_in(scl), .scl_out(), .scl_oe(scl_oe), .sda_in(sda),
		.sda_out(), .sda_oe(sda_oe), .start_evt(start_evt), .start_ack(start_ack),
		.rx_evt(rx_evt), .rx_data(rx_data), .rx_ctrl(rx_ctrl), .rx_ack(rx_ack),
		.wr_done(wr_done), .wr_crc_bad(wr_crc_bad), .xfer_abort(xfer_abort),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data));
	itsc_ctrl_model i_itsc_ctrl_model (.scl(scl), .sda(sda), .scl_o(scl_o), .sda_o(sda_o));
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	function [31:0] xs(input [31:0] s);
		begin
			xs = s ^ (s << 13);
			xs = xs ^ (xs >> 17);
			xs = xs ^ (xs << 5);
		end
	endfunction
	function [7:0] crc(input [7:0] p, input [7:0] d);
		integer i;
		begin
			crc = p ^ d;
			for (i = 0; i < 8; i = i + 1)
				crc = {crc[6:0], 1'b0} ^ (crc[7] ? 8'h07 : 8'h00);
		end
	endfunction
	task chk(input [31:0] got, input [31:0] exp);
		begin
			checks = checks + 1;
			if (got !== exp) begin
				n_fail = n_fail + 1;
				$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task final_report;
		begin
			$display("checks=%0d fails=%0d", checks, n_fail);
			if (n_fail == 0 && checks > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask
	always @(posedge ref_clk) begin
		// pulses are unknown before the first reset edge; count only true highs
		n_done <= n_done + (wr_done === 1'b1);
		n_bad <= n_bad + (wr_crc_bad === 1'b1);
		n_abt <= n_abt + (xfer_abort === 1'b1);
		tx_took <= tx_valid && tx_ready;
	end
	// user side: services events after random delays, fills the fifo
	always @(negedge ref_clk) begin
		rs = xs(rs);
		start_ack <= svc && start_evt && !start_ack && rs[0];
		rx_ack <= 1'b0;
		if (svc && !rxh && rx_evt && !rx_ack && rs[1]) begin
			rx_ack <= 1'b1;
			chk(rx_ctrl, q.size() < 3);
			q.push_back(rx_data);
		end
		if (tx_took)
			tq.delete(0);
		if (!tx_valid || tx_took) begin
			tx_valid <= tq.size() > 0 && rs[2];
			tx_data <= tq.size() > 0 ? tq[0] : 8'h00;
		end
	end
	task sb(input [7:0] v);
		begin
			i_itsc_ctrl_model.xfer(v, 1'b1, r, a);
			chk(a, 1);
			c = crc(c, v);
		end
	endtask
	task hdr(input rd, input ce, input [1:0] lc);
		begin
			n = lc == 0 ? 2 : lc == 1 ? 4 : 8;
			c = 8'hff;
			q.delete();
			e.delete();
			i_itsc_ctrl_model.start();
			sb({ADR, 1'b0});
			for (k = 0; k < 3; k = k + 1) begin
				seed = xs(seed);
				b0 = k ? seed[7:0] : {rd, ce, lc, seed[3:0]};
				sb(b0);
				e.push_back(b0);
			end
		end
	endtask
	task wr(input ce, input bad, input [1:0] lc);
		begin
			d0 = n_done;
			b1 = n_bad;
			hdr(1'b0, ce, lc);
			for (k = 0; k < n; k = k + 1) begin
				seed = xs(seed);
				sb(seed[7:0]);
				e.push_back(seed[7:0]);
			end
			if (ce)
				sb(c ^ {7'h00, bad});
			i_itsc_ctrl_model.stop();
			repeat (40) @(negedge ref_clk);
			chk(q.size(), e.size());
			foreach (q[i])
				chk(q[i], e[i]);
			chk(n_done - d0, !bad);
			chk(n_bad - b1, bad);
			$display("write len %0d crc %0d bad %0d", n, ce, bad);
		end
	endtask
	task rd(input ce, input [1:0] lc);
		begin
			hdr(1'b1, ce, lc);
			i_itsc_ctrl_model.start();
			sb({ADR, 1'b1});
			e.delete();
			// filled only now, so the first byte always meets an empty fifo
			for (k = 0; k < n; k = k + 1) begin
				seed = xs(seed);
				e.push_back(seed[7:0]);
				tq.push_back(seed[7:0]);
			end
			for (k = 0; k < n; k = k + 1) begin
				i_itsc_ctrl_model.xfer(8'hff, k == n - 1 && !ce, r, a);
				chk(r, e[k]);
				c = crc(c, e[k]);
			end
			if (ce) begin
				i_itsc_ctrl_model.xfer(8'hff, 1'b1, r, a);
				chk(r, c);
			end
			i_itsc_ctrl_model.stop();
			repeat (40) @(negedge ref_clk);
			$display("read len %0d crc %0d", n, ce);
		end
	endtask
	initial begin
		arst_n = 1'b0;
		{start_ack, rx_ack, tx_valid, tx_took, rxh, tx_data} = 0;
		svc = 1'b1;
		seed = 32'h5883536f;
		rs = seed;
		{n_fail, checks, n_done, n_bad, n_abt} = 0;
		repeat (10) @(negedge ref_clk);
		arst_n = 1'b1;
		repeat (10) @(negedge ref_clk);
		fork
			begin
				rxh = 1'b1;
				repeat (1200) @(negedge ref_clk);
				rxh = 1'b0;
			end
			wr(1'b0, 1'b0, 2'd1);
		join
		wr(1'b1, 1'b1, 2'd3);
		for (j = 0; j < 6; j = j + 1) begin
			seed = xs(seed);
			wr(seed[4], seed[4] & seed[5], seed[1:0]);
			seed = xs(seed);
			rd(seed[4], seed[1:0]);
		end
		// last control byte left unserviced across the repeated start
		fork
			begin
				repeat (50) @(negedge ref_clk);
				for (j = 0; j < 3000 && q.size() < 2; j = j + 1)
					@(negedge ref_clk);
				chk(q.size(), 2);
				rxh = 1'b1;
				repeat (1000) @(negedge ref_clk);
				rxh = 1'b0;
			end
			rd(1'b0, 2'd0);
		join
		svc = 1'b0;
		d0 = n_abt;
		i_itsc_ctrl_model.start();
		i_itsc_ctrl_model.xfer({ADR, 1'b0}, 1'b1, r, a);
		chk(a, 0);
		chk(n_abt - d0, 1);
		i_itsc_ctrl_model.stop();
		svc = 1'b1;
		i_itsc_ctrl_model.start();
		i_itsc_ctrl_model.xfer({ADR ^ 7'h01, 1'b0}, 1'b1, r, a);
		chk(a, 0);
		i_itsc_ctrl_model.stop();
		$display("timeout and foreign address");
		rd(1'b1, 2'd2);
		chk(i_itsc_ctrl_model.hung, 1'b0);
		final_report();
	end
endmodule // test_itsc_target
